// File: common/los_ais_defines.svh
// Offsets, field positions, reset values and counts of the loss and alarm detector
`ifndef LOS_AIS_DEFINES_SVH
`define LOS_AIS_DEFINES_SVH
`define REG_CTRL_ADR        8'h00
`define REG_LEVEL_ADR       8'h04
`define REG_STATUS_ADR      8'h08
`define CTRL_RESET          7'h20
`define LEVEL_CODE_RESET    5'h15
`define STS_LOS_BIT         0
`define STS_AIS_BIT         1
`define STS_EVT_BIT         2
`define DECL_N_T1_ANSI      12'h0AF
`define DECL_N_T1_ITU       12'h608
`define DECL_N_E1_ITU       12'h020
`define DECL_N_E1_ETSI      12'h800
`define CLR_M_T1            8'h80
`define CLR_M_E1            8'h20
`define CLR_MARKS_T1        8'h10
`define CLR_MARKS_E1        8'h04
`define CLR_ZRUN_T1         7'h64
`define CLR_ZRUN_E1         7'h10
`define AIS_BLK_T1          14'h2000
`define AIS_BLK_E1          14'h0200
`define AIS_ZEROS_T1        4'h9
`define AIS_ZEROS_E1        4'h3
`define LVL_SAT_CODE        5'h16
`define LVL_BASE_DB         11'h004
`define LVL_MAX_DB          11'h030
`define LVL_HYST_DB         11'h004
`define SH_Q_MV             11'h320
`define SH_HYST_MV          11'h0C8
`endif

// File: common/los_ais_pkg.sv
// Types shared by the loss and alarm detector files
package los_ais_pkg;
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic       loss_int_mask;
      logic       cdr_enable;
      logic       long_haul;
      logic       tx_alarm_fill_enable;
      logic       rx_alarm_fill_enable;
      logic       criteria_select;
      logic       line_standard_select;
   } ctrl_t;

   typedef struct packed {
      logic [10:0] q_level;
      logic [10:0] p_level;
      logic        in_mv;
   } threshold_t;

   typedef enum logic [2:0] {
      LOS_OK       = 3'b001,
      LOS_LOST     = 3'b010,
      LOS_CLEARING = 3'b100
   } los_state_t;
endpackage : los_ais_pkg

// File: hw/ais_monitor.sv
// Counts zeros per block of received bits and declares or clears the alarm signal
`include "los_ais_defines.svh"
module ais_monitor (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic enable_i,
   input  wire logic t1_mode_i,
   input  wire logic bit_tick_i,
   input  wire logic mark_i,
   output logic      alarm_o
);
   logic [13:0] bit_cnt_r;
   logic [3:0]  zero_cnt_r;
   logic        prev_sparse_r;
   logic        sparse;
   logic        blk_end;
   logic [13:0] blk_len;
   logic [3:0]  zero_lim;

   // E1 uses the same two-block criterion whatever the criteria bit says
   assign blk_len  = t1_mode_i ? `AIS_BLK_T1 : `AIS_BLK_E1;
   assign zero_lim = t1_mode_i ? `AIS_ZEROS_T1 : `AIS_ZEROS_E1;
   // A mode change can leave the count past the new block end; end that block at once
   assign blk_end  = bit_tick_i && (bit_cnt_r >= blk_len - 14'h0001);
   assign sparse   = (zero_cnt_r + {3'h0, ~mark_i}) < zero_lim;

   always_ff @(posedge clk_i) begin
      if (rst_i || !enable_i) begin
         bit_cnt_r  <= 14'h0000;
         zero_cnt_r <= 4'h0;
      end else if (blk_end) begin
         bit_cnt_r  <= 14'h0000;
         zero_cnt_r <= 4'h0;
      end else if (bit_tick_i) begin
         bit_cnt_r <= bit_cnt_r + 14'h0001;
         if (!mark_i && zero_cnt_r != zero_lim) begin
            zero_cnt_r <= zero_cnt_r + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !enable_i) begin
         alarm_o       <= 1'b0;
         prev_sparse_r <= 1'b0;
      end else if (blk_end) begin
         prev_sparse_r <= sparse;
         if (t1_mode_i) begin
            alarm_o <= sparse;
         end else if (sparse && prev_sparse_r) begin
            alarm_o <= 1'b1;
         end else if (!sparse && !prev_sparse_r) begin
            alarm_o <= 1'b0;
         end
      end
   end
endmodule : ais_monitor

// File: hw/level_threshold_map.sv
// Maps the haul mode and level code onto declare and clear thresholds
`include "los_ais_defines.svh"
module level_threshold_map (
   input  wire logic                   long_haul_i,
   input  wire logic [4:0]             level_threshold_code_i,
   output los_ais_pkg::threshold_t     thr_o
);
   import los_ais_pkg::*;
   logic [10:0] q_db;

   // Attenuation below nominal in dB: 2 dB per code step, saturating
   always_comb begin
      if (level_threshold_code_i >= `LVL_SAT_CODE) begin
         q_db = `LVL_MAX_DB;
      end else begin
         q_db = `LVL_BASE_DB + {5'h00, level_threshold_code_i, 1'b0};
      end
   end

   always_comb begin
      if (long_haul_i) begin
         thr_o.q_level = q_db;
         thr_o.p_level = q_db - `LVL_HYST_DB;
         thr_o.in_mv   = 1'b0;
      end else begin
         thr_o.q_level = `SH_Q_MV;
         thr_o.p_level = `SH_Q_MV + `SH_HYST_MV;
         thr_o.in_mv   = 1'b1;
      end
   end
endmodule : level_threshold_map

// File: hw/los_ais_detector.sv
// Loss-of-signal and alarm detector for one line channel, with Wishbone registers
// Behaviour
// - Declare loss after N intervals below Q; pin high, interrupt unless masked.
// - Clear loss after M intervals above P, 12.5% marks, window starts at a pulse.
// - T1 mode, criteria bit 0: declare after 175 intervals.
// - T1 mode, criteria bit 1: declare after 1544 intervals.
// - T1 mode: clear window 128 bits, 12.5% marks, under 100 zeros in a row.
// - E1 mode, criteria bit 0: declare after 32 intervals.
// - E1 mode, criteria bit 1: declare after 2048 intervals.
// - E1 mode: clear window 32 bits, 12.5% marks, under 16 zeros in a row.
// - Short haul: Q is 800 mVpp, P is Q plus 200 mVpp.
// - Long haul: Q from 5-bit code, P is Q plus 4 dB, code resets to -46 dB.
// - Code steps 2 dB from -4 dB; codes 10110 and above mean -48 dB.
// - Criteria set chosen from criteria bit and line standard bit together.
// - During loss, receive fill off passes data; on sends ones on master clock.
// - During loss with transmit fill on, line sends all ones on master clock.
// - Loss detection keeps running in every loopback configuration.
// - Alarm detection runs only with clock recovery enabled; result in status.
// - E1 alarm criteria fixed; the criteria bit, which resets to 0, does not pick them.
// - E1: alarm set by two blocks of 512 under 3 zeros, cleared by two with 3+.
// - T1: alarm set by 8192-bit block under 9 zeros, cleared with 9 or more.
`include "los_ais_defines.svh"
module los_ais_detector (
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  los_ais_pkg::wb_req_t        wb_i,
   output logic [31:0]                 wb_dat_o,
   output logic                        wb_ack_o,
   input  wire logic                   bit_tick_i,
   input  wire logic                   rx_data_positive_i,
   input  wire logic                   rx_data_negative_i,
   input  wire logic                   level_below_q_i,
   input  wire logic                   level_above_p_i,
   output logic                        signal_loss_pin_o,
   output logic                        loss_irq_o,
   output logic                        rx_data_positive_o,
   output logic                        rx_data_negative_o,
   output logic                        rx_clock_master_sel_o,
   output logic                        tx_alarm_ones_o,
   output los_ais_pkg::threshold_t     threshold_o
);
   import los_ais_pkg::*;

   ctrl_t       ctrl_r;
   logic [4:0]  level_threshold_code_r;
   logic        loss_event_r;
   logic        alarm_signal_status;
   los_state_t  state_r;
   los_state_t  state_nxt;
   logic [11:0] low_run_r;
   logic [7:0]  win_cnt_r;
   logic [7:0]  win_marks_r;
   logic [6:0]  zero_run_r;
   logic [11:0] decl_n;
   logic [7:0]  clr_m;
   logic [7:0]  clr_marks;
   logic [6:0]  clr_zrun;
   logic        mark;
   logic        req;
   logic        req_new;
   logic        wr_take;
   logic        zrun_hit;
   logic [7:0]  marks_sum;
   logic        los;
   logic        declare;
   logic        win_bad;
   logic        win_done;
   logic        fill_phase_r;
   threshold_t  thr;

   assign mark = rx_data_positive_i | rx_data_negative_i;
   assign los  = (state_r != LOS_OK);

   // ---- Wishbone slave ----
   assign req     = wb_i.cyc & wb_i.stb;
   // The ack cycle itself must not count as a second request
   assign req_new = req & ~wb_ack_o;
   // Writes land on the edge where the master sees ack
   assign wr_take = req & wb_i.we & wb_ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req_new;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h00000000;
      end else if (req_new) begin
         // Status is a snapshot taken at the request edge, the same edge that raises ack
         case (wb_i.adr)
            `REG_CTRL_ADR: begin
               wb_dat_o <= {25'h0000000, ctrl_r};
            end
            `REG_LEVEL_ADR: begin
               wb_dat_o <= {27'h0000000, level_threshold_code_r};
            end
            `REG_STATUS_ADR: begin
               wb_dat_o <= {29'h00000000, loss_event_r, alarm_signal_status, los};
            end
            default: begin
               wb_dat_o <= 32'h00000000;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= ctrl_t'(`CTRL_RESET);
      end else if (wr_take && wb_i.sel[0] && wb_i.adr == `REG_CTRL_ADR) begin
         ctrl_r <= ctrl_t'(wb_i.dat[6:0]);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_threshold_code_r <= `LEVEL_CODE_RESET;
      end else if (wr_take && wb_i.sel[0] && wb_i.adr == `REG_LEVEL_ADR) begin
         level_threshold_code_r <= wb_i.dat[4:0];
      end
   end

   // Sticky loss event: a new declaration in the clearing cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loss_event_r <= 1'b0;
      end else if (declare) begin
         loss_event_r <= 1'b1;
      end else if (wr_take && wb_i.sel[0] && wb_i.adr == `REG_STATUS_ADR
                   && wb_i.dat[`STS_EVT_BIT]) begin
         loss_event_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loss_irq_o <= 1'b0;
      end else begin
         loss_irq_o <= loss_event_r & ~ctrl_r.loss_int_mask;
      end
   end

   // ---- Criteria selection ----
   always_comb begin
      case ({ctrl_r.line_standard_select, ctrl_r.criteria_select})
         2'b10: begin
            decl_n = `DECL_N_T1_ANSI;
         end
         2'b11: begin
            decl_n = `DECL_N_T1_ITU;
         end
         2'b00: begin
            decl_n = `DECL_N_E1_ITU;
         end
         default: begin
            decl_n = `DECL_N_E1_ETSI;
         end
      endcase
   end

   always_comb begin
      if (ctrl_r.line_standard_select) begin
         clr_m     = `CLR_M_T1;
         clr_marks = `CLR_MARKS_T1;
         clr_zrun  = `CLR_ZRUN_T1;
      end else begin
         clr_m     = `CLR_M_E1;
         clr_marks = `CLR_MARKS_E1;
         clr_zrun  = `CLR_ZRUN_E1;
      end
   end

   // ---- Loss declare run ----
   // Detection has no loopback input at all, so no loopback can stall it
   // Saturates at N so a long outage cannot wrap the run below the declare count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         low_run_r <= 12'h000;
      end else if (bit_tick_i) begin
         if (!level_below_q_i || state_r == LOS_LOST) begin
            low_run_r <= 12'h000;
         end else if (low_run_r != decl_n) begin
            low_run_r <= low_run_r + 12'h001;
         end
      end
   end

   // The N-th low interval counts, so declare on the tick that reaches N
   assign declare = bit_tick_i && level_below_q_i && state_r == LOS_OK
                    && (low_run_r + 12'h001 >= decl_n);

   // ---- Loss clear window ----
   // A zero run that reaches the limit spoils the window although the level stays above P
   assign zrun_hit  = !mark && (zero_run_r + 7'h01 >= clr_zrun);
   assign win_bad   = !level_above_p_i || zrun_hit;
   assign win_done  = (win_cnt_r + 8'h01 == clr_m);
   // This interval's mark counts toward the density of the window it closes
   assign marks_sum = win_marks_r + {7'h00, mark};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         win_cnt_r   <= 8'h00;
         win_marks_r <= 8'h00;
         zero_run_r  <= 7'h00;
      end else if (bit_tick_i) begin
         if (state_r == LOS_LOST && mark && level_above_p_i) begin
            win_cnt_r   <= 8'h01;
            win_marks_r <= 8'h01;
            zero_run_r  <= 7'h00;
         end else if (state_r == LOS_CLEARING && !win_bad && !win_done) begin
            win_cnt_r   <= win_cnt_r + 8'h01;
            win_marks_r <= win_marks_r + {7'h00, mark};
            zero_run_r  <= mark ? 7'h00 : zero_run_r + 7'h01;
         end else begin
            win_cnt_r   <= 8'h00;
            win_marks_r <= 8'h00;
            zero_run_r  <= 7'h00;
         end
      end
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         LOS_OK: begin
            if (declare) begin
               state_nxt = LOS_LOST;
            end
         end
         LOS_LOST: begin
            if (bit_tick_i && mark && level_above_p_i) begin
               state_nxt = LOS_CLEARING;
            end
         end
         LOS_CLEARING: begin
            if (bit_tick_i && win_bad) begin
               state_nxt = LOS_LOST;
            end else if (bit_tick_i && win_done) begin
               if (marks_sum >= clr_marks) begin
                  state_nxt = LOS_OK;
               end else begin
                  state_nxt = LOS_LOST;
               end
            end
         end
         default: begin
            state_nxt = LOS_LOST;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= LOS_OK;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         signal_loss_pin_o <= 1'b0;
      end else begin
         // Taken from the next state so the pin moves on the same edge as the state
         signal_loss_pin_o <= (state_nxt != LOS_OK);
      end
   end

   // ---- Alarm fill toward system and line ----
   // Alternating marks keep the filled stream bipolar-legal
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fill_phase_r <= 1'b0;
      end else if (bit_tick_i) begin
         fill_phase_r <= ~fill_phase_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_data_positive_o    <= 1'b0;
         rx_data_negative_o    <= 1'b0;
         rx_clock_master_sel_o <= 1'b0;
      end else begin
         // The clock select is registered, so it follows the pin one cycle late
         rx_clock_master_sel_o <= los & ctrl_r.rx_alarm_fill_enable;
         if (bit_tick_i) begin
            if (los && ctrl_r.rx_alarm_fill_enable) begin
               rx_data_positive_o <= fill_phase_r;
               rx_data_negative_o <= ~fill_phase_r;
            end else begin
               rx_data_positive_o <= rx_data_positive_i;
               rx_data_negative_o <= rx_data_negative_i;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_alarm_ones_o <= 1'b0;
      end else begin
         tx_alarm_ones_o <= los & ctrl_r.tx_alarm_fill_enable;
      end
   end

   // ---- Thresholds for the analog comparator ----
   level_threshold_map u_thr (
      .long_haul_i            (ctrl_r.long_haul),
      .level_threshold_code_i (level_threshold_code_r),
      .thr_o                  (thr)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         threshold_o <= '0;
      end else begin
         // Registered so a level write cannot glitch the comparator thresholds
         threshold_o <= thr;
      end
   end

   // Alarm detection is cleared and held idle while clock recovery is off
   ais_monitor u_ais (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .enable_i   (ctrl_r.cdr_enable),
      .t1_mode_i  (ctrl_r.line_standard_select),
      .bit_tick_i (bit_tick_i),
      .mark_i     (mark),
      .alarm_o    (alarm_signal_status)
   );
endmodule : los_ais_detector

// File: tb/line_feed_model.sv
// Far-side model of the line receive path: one recovered bit per tick
module line_feed_model (
   input  wire logic clk_i,
   output logic      bit_tick_o,
   output logic      rx_data_positive_o,
   output logic      rx_data_negative_o,
   output logic      level_below_q_o,
   output logic      level_above_p_o
);
   timeunit 1ns;
   timeprecision 1ps;
   integer seed = 32'hD3A9;
   initial begin
      bit_tick_o         = 1'b0;
      rx_data_positive_o = 1'b0;
      rx_data_negative_o = 1'b1;
      level_below_q_o    = 1'b0;
      level_above_p_o    = 1'b0;
   end
   // Rails carry nothing between ticks, so each idle cycle inverts what they last showed
   task automatic idle();
      bit_tick_o         <= 1'b0;
      rx_data_positive_o <= !rx_data_positive_o;
      rx_data_negative_o <= !rx_data_negative_o;
      @(posedge clk_i);
   endtask : idle
   // mk > 0: mark every mk-th bit plus random marks; mk < 0: zero every -mk-th bit; 0: no marks
   task automatic send(input int n, input logic below, input logic above, input int mk);
      logic m;
      for (int i = 0; i < n; i++) begin
         m = (mk > 0) ? (i % mk == 0 || (mk > 1 && $random(seed) % 3 == 0))
                      : (mk < 0 && i % -mk != 0);
         bit_tick_o         <= 1'b1;
         rx_data_positive_o <= m && seed[4];
         rx_data_negative_o <= m && !seed[4];
         level_below_q_o    <= below;
         level_above_p_o    <= above;
         @(posedge clk_i);
         if ($random(seed) % 4 == 0) begin
            idle();
         end
      end
      idle();
   endtask : send
endmodule : line_feed_model

// File: tb/los_ais_checker_properties.sv
// Port-level assertions for the loss and alarm detector
module los_ais_checker (
   input wire logic               clk_i,
   input wire logic               rst_i,
   input los_ais_pkg::wb_req_t    wb_i,
   input wire logic [31:0]        wb_dat_o,
   input wire logic               wb_ack_o,
   input wire logic               bit_tick_i,
   input wire logic               rx_data_positive_i,
   input wire logic               rx_data_negative_i,
   input wire logic               level_below_q_i,
   input wire logic               level_above_p_i,
   input wire logic               signal_loss_pin_o,
   input wire logic               loss_irq_o,
   input wire logic               rx_data_positive_o,
   input wire logic               rx_data_negative_o,
   input wire logic               rx_clock_master_sel_o,
   input wire logic               tx_alarm_ones_o,
   input los_ais_pkg::threshold_t threshold_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import los_ais_pkg::*;
   logic [7:0] low_run_r;
   logic [7:0] high_run_r;
   // Saturating runs: only the smallest N and M of all modes is bounded here
   always_ff @(posedge clk_i) begin
      if (rst_i || (bit_tick_i && !level_below_q_i)) begin
         low_run_r <= 8'h00;
      end else if (bit_tick_i && !(&low_run_r)) begin
         low_run_r <= low_run_r + 8'h01;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i || (bit_tick_i && !level_above_p_i)) begin
         high_run_r <= 8'h00;
      end else if (bit_tick_i && !(&high_run_r)) begin
         high_run_r <= high_run_r + 8'h01;
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   chk_ack_next: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   chk_loss_rise: assert property ($rose(signal_loss_pin_o) |->
      $past(bit_tick_i && level_below_q_i) && low_run_r >= 8'h20)
      else $error("loss declared early");
   chk_loss_fall: assert property (!$past(rst_i) && $fell(signal_loss_pin_o) |->
      $past(bit_tick_i && level_above_p_i) && high_run_r >= 8'h20)
      else $error("loss cleared early");
   chk_rails_hold: assert property (!bit_tick_i |=>
      $stable({rx_data_positive_o, rx_data_negative_o}))
      else $error("rails moved without tick");
   chk_rails_pass: assert property (bit_tick_i && !signal_loss_pin_o |=>
      rx_data_positive_o == $past(rx_data_positive_i)
      && rx_data_negative_o == $past(rx_data_negative_i))
      else $error("rails not passed");
   chk_rx_ones: assert property (bit_tick_i && signal_loss_pin_o && rx_clock_master_sel_o |=>
      rx_data_positive_o != rx_data_negative_o)
      else $error("receive fill missing");
   chk_rx_fill: assert property (rx_clock_master_sel_o |->
      signal_loss_pin_o || $past(signal_loss_pin_o))
      else $error("master clock without loss");
   chk_tx_fill: assert property (tx_alarm_ones_o |->
      signal_loss_pin_o || $past(signal_loss_pin_o))
      else $error("line ones without loss");
   chk_thr_short: assert property (threshold_o.in_mv |->
      threshold_o.q_level == 11'h320 && threshold_o.p_level == 11'h3E8)
      else $error("short haul levels wrong");
   chk_thr_long: assert property (!threshold_o.in_mv
      && threshold_o.q_level != 11'h000 |->
      threshold_o.p_level == threshold_o.q_level - 11'h004 && threshold_o.q_level <= 11'h030
      && !threshold_o.q_level[0])
      else $error("long haul levels wrong");
   cov_declare: cover property ($rose(signal_loss_pin_o));
   cov_clear: cover property ($fell(signal_loss_pin_o));
   cov_fill: cover property (rx_clock_master_sel_o && tx_alarm_ones_o);
endmodule : los_ais_checker
bind los_ais_detector los_ais_checker los_ais_checker_i (
   .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .bit_tick_i(bit_tick_i), .rx_data_positive_i(rx_data_positive_i),
   .rx_data_negative_i(rx_data_negative_i), .level_below_q_i(level_below_q_i),
   .level_above_p_i(level_above_p_i), .signal_loss_pin_o(signal_loss_pin_o),
   .loss_irq_o(loss_irq_o), .rx_data_positive_o(rx_data_positive_o),
   .rx_data_negative_o(rx_data_negative_o), .rx_clock_master_sel_o(rx_clock_master_sel_o),
   .tx_alarm_ones_o(tx_alarm_ones_o), .threshold_o(threshold_o));

// File: tb/los_ais_detector_tb_top.sv
// Self-checking bench for the loss and alarm detector
module los_ais_detector_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import los_ais_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   wb_req_t     wb = '0;
   logic [31:0] wb_dat;
   logic [31:0] d;
   logic [31:0] cfg;
   logic        wb_ack, pin, irq, rxp, rxn, msel, tx1, tick, dp, dn, blq, abp;
   threshold_t  thr;
   int          error_cnt = 0;
   int          checks_done = 0;
   integer      seed = 32'hD3A9;
   int          n;
   int          m;
   logic [4:0]  c;
   logic [4:0]  codes [4] = '{5'h00, 5'h15, 5'h16, 5'h1F};
   logic [31:0] acfg [3] = '{32'h20, 32'h22, 32'h21};
   los_ais_detector los_ais_detector_i (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb),
      .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .bit_tick_i(tick), .rx_data_positive_i(dp),
      .rx_data_negative_i(dn), .level_below_q_i(blq), .level_above_p_i(abp),
      .signal_loss_pin_o(pin), .loss_irq_o(irq), .rx_data_positive_o(rxp),
      .rx_data_negative_o(rxn), .rx_clock_master_sel_o(msel), .tx_alarm_ones_o(tx1),
      .threshold_o(thr));
   line_feed_model line_feed_model_i (.clk_i(clk_i), .bit_tick_o(tick),
      .rx_data_positive_o(dp), .rx_data_negative_o(dn), .level_below_q_o(blq),
      .level_above_p_o(abp));
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Waits for ack without assuming a latency; the limit only guards a hang
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd);
      int t;
      t = 0;
      wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: wd};
      do begin
         @(posedge clk_i);
         t++;
      end while (wb_ack !== 1'b1 && t < 20);
      d = wb_dat;
      error_cnt += (t == 20);
      wb <= '0;
      @(posedge clk_i);
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(d & msk, e);
   endtask : rd
   function automatic logic [22:0] thr_exp(input logic lh, input logic [4:0] cd);
      logic [10:0] q;
      q = (cd > 5'h15) ? 11'h030 : 11'h004 + {5'h00, cd, 1'b0};
      return lh ? {q, q - 11'h004, 1'b0} : {11'h320, 11'h3E8, 1'b1};
   endfunction : thr_exp
   task automatic print_verdict();
      if (error_cnt == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : print_verdict
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(8'h00, 32'hFFFFFFFF, 32'h20);
      rd(8'h04, 32'hFFFFFFFF, 32'h15);
      rd(8'h08, 32'hFFFFFFFF, 32'h0);
      rd(8'h3C, 32'hFFFFFFFF, 32'h0);
      chk(32'(thr), 32'(thr_exp(1'b0, 5'h00)));
      for (int i = 0; i < 6; i++) begin
         c = (i < 4) ? codes[i] : 5'($random(seed));
         bus(1'b1, 8'h00, 32'h30);
         bus(1'b1, 8'h04, {27'h0, c});
         @(posedge clk_i);
         chk(32'(thr), 32'(thr_exp(1'b1, c)));
         rd(8'h04, 32'h1F, {27'h0, c});
      end
      for (int k = 0; k < 4; k++) begin
         n = k[1] ? (k[0] ? 1544 : 175) : (k[0] ? 2048 : 32);
         m = k[1] ? 128 : 32;
         cfg = {25'h0, k[0] ^ k[1], 2'b10, {3{k[0]}}, k[1]};
         bus(1'b1, 8'h00, cfg);
         line_feed_model_i.send(n - 1, 1'b1, 1'b0, 0);
         line_feed_model_i.send(1, 1'b0, 1'b0, 1);
         line_feed_model_i.send(n - 1, 1'b1, 1'b0, 0);
         chk(pin, 1'b0);
         line_feed_model_i.send(1, 1'b1, 1'b0, 0);
         chk(pin, 1'b1);
         rd(8'h08, 32'h5, 32'h5);
         chk({msel, tx1}, {2{k[0]}});
         chk(irq, !cfg[6]);
         bus(1'b1, 8'h08, 32'h4);
         rd(8'h08, 32'h5, 32'h1);
         chk(irq, 1'b0);
         line_feed_model_i.send(m - 1, 1'b0, 1'b1, 4);
         chk(pin, 1'b1);
         line_feed_model_i.send(1, 1'b0, 1'b1, 4);
         @(posedge clk_i);
         chk({pin, msel, tx1}, 3'b000);
      end
      for (int k = 0; k < 3; k++) begin
         n = acfg[k][0] ? 16384 : 1536;
         bus(1'b1, 8'h00, acfg[k]);
         line_feed_model_i.send(n, 1'b0, 1'b1, 1);
         rd(8'h08, 32'h2, 32'h2);
         line_feed_model_i.send(n, 1'b0, 1'b1, -64);
         rd(8'h08, 32'h2, 32'h0);
      end
      bus(1'b1, 8'h00, 32'h00);
      line_feed_model_i.send(1536, 1'b0, 1'b1, 1);
      rd(8'h08, 32'h2, 32'h0);
      print_verdict();
   end
   initial begin
      // About 62k cycles are expected; the limit leaves room yet stays inside the budget
      repeat (90000) @(posedge clk_i);
      error_cnt++;
      print_verdict();
   end
endmodule : los_ais_detector_tb_top
